// file: logic/asf_top.sv
// Summary of operation
// - Buffer holds exactly twelve frames until the controller reads them.
// - Each frame is 56 bits: 8 status/pin bits, two 24-bit words.
// - Threshold field in config two; alert once fill reaches it.
// - Two-bit select picks which general-purpose pin carries the alert.
// - Format 000 packs two consecutive conversions of the one active channel.
// - Single layout: status1, status2, pin1, pin2, result1, result2.
// - Format 001 packs one simultaneous conversion of each enabled channel.
// - Dual layout: 5-bit status, zero bit, 2 pin bits, ch1, ch2.
// - Frames are sent without any CRC, in both formats.
// - Read command failing its CRC is discarded, no data driven.
// - Disabled buffer returns invalid data, pointers and contents untouched.
// - On threshold, signal on result-ready or a pin, then await read.
// - Alert pulse (pin high, result-ready low) at least 4 us, only when interrupt enabled.
// - Error flag when pointers differ while the buffer is disabled.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
module asf_top #(
  parameter int DEPTH = asf_pkg::DEPTH
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire asf_pkg::asf_conv_type conv_in,
  input wire logic conv_valid_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic result_ready_n_out,
  output logic [3:0] gpio_alert_out,
  output logic irq_out
);
  localparam int AC = asf_pkg::ALERT_CYC;
  localparam logic [7:0] ALERT_LOAD = 8'(AC - 1);
  localparam logic [4:0] DEPTH_LVL = 5'(DEPTH);
  localparam logic [3:0] LAST_PTR = 4'(DEPTH - 1);

  if (DEPTH < 2 || DEPTH > 15 || AC < 1 || AC > 255) begin : g_chk
    $error("asf_top: DEPTH or alert length out of range");
  end

  typedef enum logic {ST_CMD, ST_SEND} asf_state_type;

  function automatic logic [3:0] asf_next_ptr(input logic [3:0] p);
    return (p == LAST_PTR) ? 4'h0 : 4'(p + 4'h1);
  endfunction

  function automatic logic [7:0] asf_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = asf_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ asf_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Registers
  logic en_r, ien_r, route_r, pd1_r, pd2_r;
  logic [2:0] fmt_r;
  logic [3:0] thr_r;
  logic [1:0] sel_r;
  logic [3:0] irq_stat_r, irq_mask_r, irq_stat_nxt, ev_set;
  logic wait_r, acc, wr_en;
  logic [31:0] rd_mux;

  function automatic logic asf_wr_hit(input logic [4:0] a, input logic w,
                                      input logic be, input logic [4:0] o);
    return w && be && (a == o);
  endfunction

  assign acc = (avs_read_in || avs_write_in) && wait_r;
  assign wr_en = avs_write_in && !wait_r;

  // One wait cycle per access keeps read data a plain register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_r <= 1'b1;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      wait_r <= !acc;
      avs_waitrequest_out <= !acc;
      if (acc && avs_read_in) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // FIFO state
  logic [3:0] wr_ptr_r, rd_ptr_r;
  logic [4:0] fill_r, fill_nxt;
  logic push_r, push_ok, pop_r, err_cond, reach;
  logic [55:0] frame_r, mem_q;

  assign err_cond = !en_r && ((rd_ptr_r != wr_ptr_r) || (fill_r != 5'h00));

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      asf_pkg::OFS_CFG_ONE: begin
        rd_mux[asf_pkg::CFG1_EN_BIT] = en_r;
        rd_mux[asf_pkg::CFG1_IEN_BIT] = ien_r;
        rd_mux[asf_pkg::CFG1_FMT_LSB +: 3] = fmt_r;
        rd_mux[asf_pkg::CFG1_ROUTE_BIT] = route_r;
      end
      asf_pkg::OFS_CFG_TWO: begin
        rd_mux[asf_pkg::CFG2_THR_LSB +: 4] = thr_r;
        rd_mux[asf_pkg::CFG2_SEL_LSB +: 2] = sel_r;
      end
      asf_pkg::OFS_LEVEL: begin
        rd_mux[4:0] = fill_r;
        rd_mux[asf_pkg::LEVEL_ERR_BIT] = err_cond;
      end
      asf_pkg::OFS_IRQ_STAT: rd_mux[3:0] = irq_stat_r;
      asf_pkg::OFS_IRQ_MASK: rd_mux[3:0] = irq_mask_r;
      asf_pkg::OFS_CH_SETUP: begin
        rd_mux[asf_pkg::CH_PD1_BIT] = pd1_r;
        rd_mux[asf_pkg::CH_PD2_BIT] = pd2_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_r <= 1'b0;
      ien_r <= 1'b0;
      route_r <= 1'b0;
      fmt_r <= asf_pkg::FMT_RST;
      thr_r <= asf_pkg::THR_RST;
      sel_r <= asf_pkg::SEL_RST;
      pd1_r <= 1'b0;
      pd2_r <= 1'b0;
      irq_mask_r <= asf_pkg::MASK_RST;
    end else begin
      if (asf_wr_hit(avs_address_in, wr_en, avs_byteenable_in[0],
                     asf_pkg::OFS_CFG_ONE)) begin
        en_r <= avs_writedata_in[asf_pkg::CFG1_EN_BIT];
        ien_r <= avs_writedata_in[asf_pkg::CFG1_IEN_BIT];
        fmt_r <= avs_writedata_in[asf_pkg::CFG1_FMT_LSB +: 3];
        route_r <= avs_writedata_in[asf_pkg::CFG1_ROUTE_BIT];
      end
      if (asf_wr_hit(avs_address_in, wr_en, avs_byteenable_in[0],
                     asf_pkg::OFS_CFG_TWO)) begin
        thr_r <= avs_writedata_in[asf_pkg::CFG2_THR_LSB +: 4];
        sel_r <= avs_writedata_in[asf_pkg::CFG2_SEL_LSB +: 2];
      end
      if (asf_wr_hit(avs_address_in, wr_en, avs_byteenable_in[0],
                     asf_pkg::OFS_CH_SETUP)) begin
        pd1_r <= avs_writedata_in[asf_pkg::CH_PD1_BIT];
        pd2_r <= avs_writedata_in[asf_pkg::CH_PD2_BIT];
      end
      if (asf_wr_hit(avs_address_in, wr_en, avs_byteenable_in[0],
                     asf_pkg::OFS_IRQ_MASK)) begin
        irq_mask_r <= avs_writedata_in[3:0];
      end
    end
  end

  // Frame assembly
  asf_pkg::asf_half_type cur_half, hold_r;
  logic hold_vld_r;
  logic ch1_on, ch2_on;
  assign ch1_on = !pd1_r;
  assign ch2_on = !pd2_r;
  assign cur_half = ch1_on ?
    {conv_in.open_ch1, conv_in.gpio[0], conv_in.ch1} :
    {conv_in.open_ch2, conv_in.gpio[0], conv_in.ch2};

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      push_r <= 1'b0;
      frame_r <= 56'h0;
      hold_r <= '0;
      hold_vld_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (!en_r || fmt_r != asf_pkg::FMT_SINGLE) begin
        hold_vld_r <= 1'b0;
      end
      if (conv_valid_in && en_r && (ch1_on || ch2_on)) begin
        case (fmt_r)
          asf_pkg::FMT_SINGLE: begin
            if (hold_vld_r) begin
              frame_r <= {hold_r.open, cur_half.open, hold_r.gpio,
                          cur_half.gpio, hold_r.result,
                          cur_half.result};
              push_r <= 1'b1;
              hold_vld_r <= 1'b0;
            end else begin
              hold_r <= cur_half;
              hold_vld_r <= 1'b1;
            end
          end
          asf_pkg::FMT_DUAL: begin
            frame_r <= {conv_in.open_all, 1'b0, conv_in.gpio,
                        ch1_on ? conv_in.ch1 : 24'h000000,
                        ch2_on ? conv_in.ch2 : 24'h000000};
            push_r <= 1'b1;
          end
          default: push_r <= 1'b0;
        endcase
      end
    end
  end

  // Storage and pointers
  assign push_ok = push_r && (fill_r != DEPTH_LVL);
  assign fill_nxt = 5'(fill_r + {4'h0, push_ok} - {4'h0, pop_r});
  assign reach = en_r && (thr_r != 4'h0) && (fill_r < {1'b0, thr_r}) &&
                 (fill_nxt >= {1'b0, thr_r});

  asf_frame_mem #(
    .WIDTH(asf_pkg::FRAME_W),
    .DEPTH(DEPTH),
    .AW(asf_pkg::PTR_W)
  ) u_mem (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(push_ok),
    .wr_addr_in(wr_ptr_r),
    .wr_data_in(frame_r),
    .rd_addr_in(rd_ptr_r),
    .rd_data_out(mem_q)
  );

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      fill_r <= 5'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= asf_next_ptr(wr_ptr_r);
      end
      if (pop_r) begin
        rd_ptr_r <= asf_next_ptr(rd_ptr_r);
      end
      fill_r <= fill_nxt;
    end
  end

  // Events, set wins over write-one-to-clear
  always_comb begin
    ev_set = 4'h0;
    ev_set[asf_pkg::EV_THR] = reach;
    ev_set[asf_pkg::EV_ERR] = err_cond;
    ev_set[asf_pkg::EV_OVF] = push_r && !push_ok;
    ev_set[asf_pkg::EV_DROP] = 1'b0;
    irq_stat_nxt = irq_stat_r;
    if (asf_wr_hit(avs_address_in, wr_en, avs_byteenable_in[0],
                   asf_pkg::OFS_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_nxt & ~avs_writedata_in[3:0];
    end
  end

  logic drop_ev;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_r <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt | ev_set |
                    {1'b0, drop_ev, 2'h0};
      irq_out <= |((irq_stat_nxt | ev_set |
                    {1'b0, drop_ev, 2'h0}) & irq_mask_r);
    end
  end

  // Alert pulse on the selected pin or result-ready
  logic alert_act_r;
  logic [7:0] alert_cnt_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alert_act_r <= 1'b0;
      alert_cnt_r <= 8'h00;
      gpio_alert_out <= 4'h0;
      result_ready_n_out <= 1'b1;
    end else begin
      if (reach && ien_r) begin
        alert_act_r <= 1'b1;
        alert_cnt_r <= ALERT_LOAD;
      end else if (alert_cnt_r != 8'h00) begin
        alert_cnt_r <= alert_cnt_r - 8'h01;
      end else begin
        alert_act_r <= 1'b0;
      end
      gpio_alert_out <= (alert_act_r && route_r) ?
                        (4'h1 << sel_r) : 4'h0;
      result_ready_n_out <= !(alert_act_r && !route_r);
    end
  end

  // Serial port, sampled by clk_in
  asf_pkg::asf_link_type link_s1_r, link_s2_r;
  logic sclk_d_r, rise, fall, avail_r;
  asf_state_type state_r;
  logic [23:0] cmd_sh_r, cmd_word;
  logic [4:0] cmd_cnt_r;
  logic [5:0] bit_cnt_r;
  logic [3:0] frames_left_r;
  logic [55:0] sh_r, load_frame;
  logic cmd_done, cmd_ok;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_s1_r <= 3'h2;
      link_s2_r <= 3'h2;
      sclk_d_r <= 1'b0;
      avail_r <= 1'b0;
    end else begin
      link_s1_r <= {sclk_in, cs_n_in, din_in};
      link_s2_r <= link_s1_r;
      sclk_d_r <= link_s2_r.sclk;
      avail_r <= (fill_r != 5'h00);
    end
  end

  assign rise = link_s2_r.sclk && !sclk_d_r;
  assign fall = !link_s2_r.sclk && sclk_d_r;
  assign cmd_word = {cmd_sh_r[22:0], link_s2_r.din};
  assign cmd_done = (state_r == ST_CMD) && !link_s2_r.cs_n && fall &&
                    (cmd_cnt_r == 5'(asf_pkg::CMD_BITS - 1));
  assign cmd_ok = (cmd_word[23:16] == asf_pkg::OPC_READ_BUF) &&
                  (asf_crc8(cmd_word[23:8]) == cmd_word[7:0]);
  assign drop_ev = cmd_done && !cmd_ok;
  // Disabled or empty reads give filler and never move the pointers
  assign load_frame = (en_r && avail_r) ? mem_q :
                      asf_pkg::INVALID_FRAME;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_CMD;
      cmd_sh_r <= 24'h000000;
      cmd_cnt_r <= 5'h00;
      bit_cnt_r <= 6'h00;
      frames_left_r <= 4'h0;
      sh_r <= 56'h0;
      pop_r <= 1'b0;
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
    end else begin
      pop_r <= 1'b0;
      if (link_s2_r.cs_n) begin
        state_r <= ST_CMD;
        cmd_cnt_r <= 5'h00;
        bit_cnt_r <= 6'h00;
        dout_oe_out <= 1'b0;
        dout_out <= 1'b0;
      end else begin
        unique case (state_r)
          ST_CMD: begin
            if (fall) begin
              cmd_sh_r <= cmd_word;
              cmd_cnt_r <= cmd_done ? 5'h00 : 5'(cmd_cnt_r + 5'h01);
              if (cmd_done && cmd_ok && cmd_word[15:8] != 8'h00) begin
                state_r <= ST_SEND;
                frames_left_r <= (cmd_word[15:8] > 8'(DEPTH)) ?
                                 4'(DEPTH) : cmd_word[11:8];
                bit_cnt_r <= 6'h00;
              end
            end
          end
          ST_SEND: begin
            if (rise) begin
              if (bit_cnt_r != 6'h00) begin
                dout_out <= sh_r[55];
                sh_r <= {sh_r[54:0], 1'b0};
                bit_cnt_r <= bit_cnt_r - 6'h01;
              end else if (frames_left_r == 4'h0) begin
                state_r <= ST_CMD;
                dout_oe_out <= 1'b0;
                dout_out <= 1'b0;
              end else begin
                dout_out <= load_frame[55];
                sh_r <= {load_frame[54:0], 1'b0};
                bit_cnt_r <= 6'(asf_pkg::FRAME_W - 1);
                frames_left_r <= frames_left_r - 4'h1;
                pop_r <= en_r && avail_r;
                dout_oe_out <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Checks
  logic pin_act;
  logic [7:0] len_r;
  assign pin_act = (|gpio_alert_out) || !result_ready_n_out;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      len_r <= 8'h00;
    end else begin
      len_r <= pin_act ? ((len_r == 8'hFF) ? len_r : len_r + 8'h01) : 8'h00;
    end
  end

  a_depth_bound:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      fill_r <= DEPTH_LVL)
    else $error("fill level above depth");
  a_fill_up:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (push_ok && !pop_r) |=> fill_r == 5'($past(fill_r) + 5'h01))
    else $error("fill did not count a stored frame");
  a_fill_down:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pop_r && !push_ok) |=> fill_r == 5'($past(fill_r) - 5'h01))
    else $error("fill did not count a read frame");
  a_off_hold:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (!en_r && !push_r) |=> $stable(rd_ptr_r) && $stable(wr_ptr_r))
    else $error("pointers moved while disabled");
  a_pulse_width:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $fell(pin_act) |-> len_r >= 8'(AC))
    else $error("alert pulse too short");
  a_alert_gate:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $rose(alert_act_r) |-> $past(ien_r) && $past(reach))
    else $error("alert without enable or threshold");
  a_crc_drop:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      drop_ev |=> state_r == ST_CMD && !dout_oe_out ##1
                  irq_stat_r[asf_pkg::EV_DROP])
    else $error("bad command was not discarded");
  a_dual_zero:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (conv_valid_in && en_r && fmt_r == asf_pkg::FMT_DUAL && ch2_on)
      |=> push_r && !frame_r[50] && frame_r[23:0] == $past(conv_in.ch2))
    else $error("dual frame layout wrong");
  a_err_flag:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      err_cond |=> irq_stat_r[asf_pkg::EV_ERR])
    else $error("buffer error not flagged");
endmodule

// file: logic/asf_pkg.sv
package asf_pkg;
  localparam int DEPTH = 12;
  localparam int FRAME_W = 56;
  localparam int RES_W = 24;
  localparam int PTR_W = 4;
  localparam int LVL_W = 5;
  localparam int EV_W = 4;
  localparam int CMD_BITS = 24;
  localparam logic [4:0] OFS_CFG_ONE = 5'h00;
  localparam logic [4:0] OFS_CFG_TWO = 5'h04;
  localparam logic [4:0] OFS_LEVEL = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
  localparam logic [4:0] OFS_CH_SETUP = 5'h14;
  localparam int CFG1_EN_BIT = 0;
  localparam int CFG1_IEN_BIT = 1;
  localparam int CFG1_FMT_LSB = 2;
  localparam int CFG1_ROUTE_BIT = 5;
  localparam int CFG2_THR_LSB = 0;
  localparam int CFG2_SEL_LSB = 4;
  localparam int CH_PD1_BIT = 0;
  localparam int CH_PD2_BIT = 1;
  localparam int LEVEL_ERR_BIT = 8;
  localparam int EV_THR = 0;
  localparam int EV_ERR = 1;
  localparam int EV_DROP = 2;
  localparam int EV_OVF = 3;
  localparam logic [3:0] THR_RST = 4'h6;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [2:0] FMT_RST = 3'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] FMT_SINGLE = 3'h0;
  localparam logic [2:0] FMT_DUAL = 3'h1;
  localparam logic [7:0] OPC_READ_BUF = 8'h5A;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [55:0] INVALID_FRAME = 56'hFFFFFFFFFFFFFF;
  localparam int CLK_HZ = 20000000;
  localparam int ALERT_MIN_NS = 4000;
  localparam int ALERT_CYC = (ALERT_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef struct packed {
    logic [4:0] open_all;
    logic [2:0] open_ch1;
    logic [2:0] open_ch2;
    logic [1:0] gpio;
    logic [23:0] ch1;
    logic [23:0] ch2;
  } asf_conv_type;

  typedef struct packed {
    logic [2:0] open;
    logic gpio;
    logic [23:0] result;
  } asf_half_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } asf_link_type;
endpackage

// file: logic/asf_frame_mem.sv
module asf_frame_mem #(
  parameter int WIDTH = asf_pkg::FRAME_W,
  parameter int DEPTH = asf_pkg::DEPTH,
  parameter int AW = asf_pkg::PTR_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("asf_frame_mem: DEPTH exceeds address range");
  end

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// file: tb/asf_mcu_model.sv
module asf_mcu_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out,
  input wire logic dout_in,
  input wire logic dout_oe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [55:0] got_q[$];
  logic oe_seen;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
    oe_seen = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = asf_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? asf_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Clock idles low; only the buffer read is ever issued
  task automatic read_cmd(input int cnt, input bit bad);
    logic [23:0] cmd;
    logic [55:0] f;
    int n;
    n = (cnt > asf_pkg::DEPTH) ? asf_pkg::DEPTH : cnt;
    cmd = {asf_pkg::OPC_READ_BUF, 8'(n), 8'h00};
    cmd[7:0] = crc8(cmd[23:8]) ^ {7'h00, bad};
    oe_seen = 1'b0;
    #17 cs_n_out = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--) begin
      sclk_out = 1'b1;
      din_out = cmd[i];
      #200 sclk_out = 1'b0;
      #200;
    end
    for (int k = 0; k < n; k++) begin
      for (int b = 55; b >= 0; b--) begin
        // Input unused now, toggled so a stale level cannot pass
        sclk_out = 1'b1;
        din_out = ~din_out;
        #200 sclk_out = 1'b0;
        // Sample late: output may move up to three clocks after the rise
        #195 f[b] = dout_oe_in ? dout_in : 1'bx;
        oe_seen = oe_seen | dout_oe_in;
        #5;
      end
      got_q.push_back(f);
    end
    #400 cs_n_out = 1'b1;
    din_out = ~din_out;
    #400;
  endtask
endmodule

// file: tb/asf_top_tb.sv
module asf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, arst_n_in, avs_read, avs_write, conv_valid, wait_o;
  logic [4:0] avs_addr;
  logic [31:0] avs_wdata, rdata_o, rd;
  asf_pkg::asf_conv_type conv, half;
  logic sclk, cs_n, din, dout, dout_oe, rdy_n, irq;
  logic [3:0] gpio_alert;
  logic [55:0] exp_q[$];
  bit half_full;
  int failures, check_count;

  asf_top #(.DEPTH(asf_pkg::DEPTH)) i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_addr),
    .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_byteenable_in(4'hF), .avs_writedata_in(avs_wdata),
    .avs_readdata_out(rdata_o), .avs_waitrequest_out(wait_o),
    .conv_in(conv), .conv_valid_in(conv_valid), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .result_ready_n_out(rdy_n), .gpio_alert_out(gpio_alert), .irq_out(irq)
  );
  asf_mcu_model i_mcu (
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe)
  );

  always #25 clk_in = ~clk_in;

  task automatic chk_word(logic [31:0] got, logic [31:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_frame(logic [55:0] got, logic [55:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic av(logic [4:0] a, bit wr, logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk_in);
    avs_addr <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_wdata <= d;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk_in);
      if (wait_o === 1'b0) begin
        rd = rdata_o;
        done = 1;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!done) begin
      failures++;
      test_done();
    end
  endtask

  task automatic rchk(logic [4:0] a, logic [31:0] e, string m);
    av(a, 1'b0, 32'h0);
    chk_word(rd, e, m);
  endtask

  // Model packs frames; single format runs with channel two active
  task automatic push(bit dual);
    asf_pkg::asf_conv_type c;
    logic [55:0] f;
    c = 61'({$urandom(), $urandom()});
    @(posedge clk_in);
    conv <= c;
    conv_valid <= 1'b1;
    @(posedge clk_in);
    conv_valid <= 1'b0;
    if (dual)
      f = {c.open_all, 1'b0, c.gpio, c.ch1, c.ch2};
    else
      f = {half.open_ch2, c.open_ch2, half.gpio[0], c.gpio[0],
           half.ch2, c.ch2};
    if ((dual || half_full) && exp_q.size() < asf_pkg::DEPTH)
      exp_q.push_back(f);
    half_full = !dual && !half_full;
    half = c;
  endtask

  task automatic rd_frames(int n, bit bad, bit live);
    i_mcu.got_q.delete();
    i_mcu.read_cmd(n, bad);
    if (bad)
      chk_word({31'h0, i_mcu.oe_seen}, 32'h0, "dout driven");
    for (int i = 0; i < n && !bad; i++)
      chk_frame(i_mcu.got_q[i], (live && exp_q.size() > 0) ?
                exp_q.pop_front() : asf_pkg::INVALID_FRAME, "frame");
  endtask

  task automatic chk_alert(int pin, int len);
    int cnt;
    bit seen;
    cnt = 0;
    seen = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (pin < 0 ? (rdy_n === 1'b0) : (gpio_alert[pin] === 1'b1)) begin
        if (!seen)
          chk_word({27'h0, rdy_n, gpio_alert},
                   pin < 0 ? 32'h0 : 32'h10 | (32'h1 << pin), "pins");
        seen = 1;
        cnt++;
      end else if (seen || i > 30)
        break;
    end
    chk_word(32'(cnt), 32'(len), "alert width");
  endtask

  task automatic test_done();
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #4000000;
    failures++;
    test_done();
  end

  initial begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_addr = 5'h00;
    avs_wdata = 32'h0;
    conv = '0;
    half = '0;
    conv_valid = 1'b0;
    void'($urandom(32'h1E894A5C));
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rchk(5'h00, 32'h0, "cfg1");
    rchk(5'h04, {26'h0, asf_pkg::SEL_RST, asf_pkg::THR_RST}, "cfg2");
    rchk(5'h18, 32'h0, "unmapped");
    rd_frames(1, 0, 0);
    rchk(5'h08, 32'h0, "lvl");
    av(5'h00, 1, 32'h07);
    repeat (5) push(1);
    push(1);
    chk_alert(-1, asf_pkg::ALERT_CYC);
    rchk(5'h0C, 32'h1, "stat");
    chk_word({31'h0, irq}, 32'h0, "masked irq");
    av(5'h10, 1, 32'h1);
    repeat (3) @(posedge clk_in);
    chk_word({31'h0, irq}, 32'h1, "irq");
    av(5'h0C, 1, 32'h1);
    repeat (3) @(posedge clk_in);
    chk_word({31'h0, irq}, 32'h0, "irq clr");
    // Thirteen pushes: the last must be dropped
    repeat (7) push(1);
    rchk(5'h08, 32'h0000000C, "lvl");
    rchk(5'h0C, 32'h8, "stat");
    rd_frames(12, 0, 1);
    rchk(5'h08, 32'h0, "lvl");
    av(5'h14, 1, 32'h1);
    av(5'h04, 1, 32'h2);
    av(5'h00, 1, 32'h01);
    repeat (3) push(0);
    push(0);
    chk_alert(-1, 0);
    rchk(5'h08, 32'h2, "lvl");
    rd_frames(2, 0, 1);
    repeat (2) push(0);
    rd_frames(1, 1, 1);
    rchk(5'h08, 32'h1, "lvl");
    av(5'h0C, 0, 32'h0);
    chk_word(rd & 32'h4, 32'h4, "crc stat");
    av(5'h00, 1, 32'h0);
    rchk(5'h08, 32'h101, "lvl err");
    av(5'h0C, 0, 32'h0);
    chk_word(rd & 32'h2, 32'h2, "err stat");
    rd_frames(1, 0, 0);
    rchk(5'h08, 32'h101, "lvl");
    av(5'h00, 1, 32'h01);
    rd_frames(1, 0, 1);
    av(5'h14, 1, 32'h0);
    av(5'h00, 1, 32'h27);
    for (int s = 0; s < 4; s++) begin
      av(5'h04, 1, 32'h1 | (s << 4));
      push(1);
      chk_alert(s, asf_pkg::ALERT_CYC);
      rd_frames(1, 0, 1);
    end
    // Reserved format code: a conversion must not be stored
    av(5'h00, 1, 32'h09);
    @(posedge clk_in);
    conv_valid <= 1'b1;
    @(posedge clk_in);
    conv_valid <= 1'b0;
    rchk(5'h08, 32'h0, "lvl fmt");
    test_done();
  end
endmodule
